// file: shared/spfs_pkg.sv
// Package for the pin function selector: register map, masks, codes.
// Assumes a 32-bit AHB-Lite bus, one word per 8-bit register.
package spfs_pkg;
  localparam int unsigned NREG = 14;
  localparam logic [3:0] IDX_INPUT_ROUTE_SELECT_A  = 4'h0;
  localparam logic [3:0] IDX_INPUT_ROUTE_SELECT_B  = 4'h1;
  localparam logic [3:0] IDX_PORT_A_FUNC_SEL_LOW   = 4'h2;
  localparam logic [3:0] IDX_PORT_A_FUNC_SEL_HIGH  = 4'h3;
  localparam logic [3:0] IDX_PORT_B_FUNC_SEL_LOW   = 4'h4;
  localparam logic [3:0] IDX_PORT_B_FUNC_SEL_HIGH  = 4'h5;
  localparam logic [3:0] IDX_PORT_C_FUNC_SEL_LOW   = 4'h6;
  localparam logic [3:0] IDX_PORT_C_FUNC_SEL_HIGH  = 4'h7;
  localparam logic [3:0] IDX_PORT_D_FUNC_SEL_LOW   = 4'h8;
  localparam logic [3:0] IDX_PORT_D_FUNC_SEL_HIGH  = 4'h9;
  localparam logic [3:0] IDX_PORT_E_FUNC_SEL_LOW   = 4'ha;
  localparam logic [3:0] IDX_PORT_E_FUNC_SEL_HIGH  = 4'hb;
  localparam logic [3:0] IDX_PORT_F_FUNC_SEL_LOW   = 4'hc;
  localparam logic [3:0] IDX_PORT_F_FUNC_SEL_HIGH  = 4'hd;
  // Byte address is four times the index
  localparam logic [7:0] SEL_RESET = 8'h00;
  // Implemented bits per register, index order
  localparam logic [7:0] MASK [NREG] = '{8'hc9, 8'h71, 8'hff, 8'hff, 8'hfc, 8'hff, 8'hff,
                                         8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h3f};
  // Field positions in the port A selectors
  localparam int unsigned POS_PIN0 = 0;
  localparam int unsigned POS_PIN1 = 2;
  localparam int unsigned POS_PIN2 = 4;
  localparam int unsigned POS_PIN3 = 6;
  localparam int unsigned POS_PIN6 = 4;
  // Input route bits
  localparam int unsigned POS_STANDARD_TIMER_CLOCK_INPUT_ROUTE = 0;
  localparam int unsigned POS_SERIAL_A_DATA_IN_ROUTE = 5;
  // Field codes
  localparam logic [1:0] CODE_00 = 2'h0;
  localparam logic [1:0] CODE_01 = 2'h1;
  localparam logic [1:0] CODE_10 = 2'h2;
  localparam logic [1:0] CODE_11 = 2'h3;
endpackage

// file: rtl/spfs_top.sv
// Pin function selector for port A pins 0..3 and 6, with an AHB-Lite register file.
// Assumes pins arrive unsynchronised; peripheral and port signals share hclk.
// How it works
// - Pin 3 field bits 7..6: 00 gpio with timer1 capture, 01 timer1 out, 10 serial A data out, 11 crystal out.
// - Pin 2 field bits 5..4: 00, 01, 10 gpio with timer0 clock input, 11 low-speed crystal b.
// - Pin 1 field bits 3..2: 00, 01 gpio with interrupt zero and timer clock, 10 voltage detect, 11 timer0 inverted.
// - Pin 0 field bits 1..0: 00, 01 gpio with timer0 capture, 10 timer0 out, 11 low-speed crystal a.
// - Every port has output selector registers of 2-bit fields, one per pin.
// - Input route registers pick which pin feeds a peripheral input, apart from the output fields.
// - Digital inputs except pin 6 serial in share the gpio code, and the pin feeds both the port and the peripheral.
// - Pin 6 field bits 5..4 of the high selector: 00 or 11 gpio with timer clock, 01 serial in, 10 serial clock.
`timescale 1ns/100ps
module spfs_top (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Pins, index 0..3 = pins 0..3, index 4 = pin 6
  input  wire logic [4:0]  port_a_pin_in,
  output logic [4:0]       port_a_pin_out,
  output logic [4:0]       port_a_pin_oe,
  output logic [4:0]       pin_analog_en,
  // Port logic
  input  wire logic [4:0]  gpio_out,
  input  wire logic [4:0]  gpio_oe,
  output logic [4:0]       gpio_in,
  // Peripheral outputs
  input  wire logic        timer1_output,
  input  wire logic        serial_a_data_out,
  input  wire logic        timer0_output,
  input  wire logic        timer0_inverted_output,
  input  wire logic        serial_clock_out,
  input  wire logic        serial_clock_oe,
  // Alternate serial A data pin from another port
  input  wire logic        serial_a_data_in_alt_pin,
  // Peripheral inputs
  output logic             timer1_capture_input,
  output logic             timer0_clock_input,
  output logic             external_interrupt_zero,
  output logic             standard_timer_clock_input,
  output logic             voltage_detect_en,
  output logic             timer0_capture_input,
  output logic             serial_a_data_in
);

  logic [7:0] sel_reg [spfs_pkg::NREG];
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic       wr_pend;
  logic [3:0] wr_idx;

  // Bus decode; zero wait states so hready is always ours
  wire        addr_ph  = hsel & htrans[1] & hready;
  wire [3:0]  a_idx    = haddr[5:2];
  wire        a_mapped = (haddr[31:6] == 26'h0) && (a_idx < 4'(spfs_pkg::NREG));
  wire [7:0]  wr_val   = hwdata[7:0] & spfs_pkg::MASK[wr_idx];

  // Read with forwarding of a write still in its data phase
  wire [7:0]  rd_val   = (wr_pend && wr_idx == a_idx) ? wr_val : sel_reg[a_idx];
  wire [31:0] next_hrdata = (addr_ph && !hwrite && a_mapped) ? {24'h0, rd_val} : 32'h0;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_idx    <= 4'h0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= addr_ph & hwrite & a_mapped;
      wr_idx    <= a_idx;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Selector storage, every port gets its two registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < spfs_pkg::NREG; i++) begin
        sel_reg[i] <= spfs_pkg::SEL_RESET;
      end
    end else if (wr_pend) begin
      sel_reg[wr_idx] <= wr_val;
    end
  end

  // Two-flop synchroniser for pins and the alternate data pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta <= 6'h0;
      pin_sync <= 6'h0;
    end else begin
      pin_meta <= {serial_a_data_in_alt_pin, port_a_pin_in};
      pin_sync <= pin_meta;
    end
  end

  // Field extraction
  wire [7:0] pa_low  = sel_reg[spfs_pkg::IDX_PORT_A_FUNC_SEL_LOW];
  wire [7:0] pa_high = sel_reg[spfs_pkg::IDX_PORT_A_FUNC_SEL_HIGH];
  wire [7:0] route_a = sel_reg[spfs_pkg::IDX_INPUT_ROUTE_SELECT_A];
  wire [7:0] route_b = sel_reg[spfs_pkg::IDX_INPUT_ROUTE_SELECT_B];
  wire [1:0] pin0_function_field = pa_low[spfs_pkg::POS_PIN0 +: 2];
  wire [1:0] pin1_function_field = pa_low[spfs_pkg::POS_PIN1 +: 2];
  wire [1:0] pin2_function_field = pa_low[spfs_pkg::POS_PIN2 +: 2];
  wire [1:0] pin3_function_field = pa_low[spfs_pkg::POS_PIN3 +: 2];
  wire [1:0] pin6_function_field = pa_high[spfs_pkg::POS_PIN6 +: 2];
  wire       standard_timer_clock_input_from_pin6 = route_a[spfs_pkg::POS_STANDARD_TIMER_CLOCK_INPUT_ROUTE];
  wire       serial_a_data_in_from_alt  = route_b[spfs_pkg::POS_SERIAL_A_DATA_IN_ROUTE];

  // Gpio codes per pin; shared inputs ride on these
  wire gpio0 = pin0_function_field == spfs_pkg::CODE_00 || pin0_function_field == spfs_pkg::CODE_01;
  wire gpio1 = pin1_function_field == spfs_pkg::CODE_00 || pin1_function_field == spfs_pkg::CODE_01;
  wire gpio2 = pin2_function_field != spfs_pkg::CODE_11;
  wire gpio3 = pin3_function_field == spfs_pkg::CODE_00;
  wire gpio6 = pin6_function_field == spfs_pkg::CODE_00 || pin6_function_field == spfs_pkg::CODE_11;
  wire [4:0] gpio_sel = {gpio6, gpio3, gpio2, gpio1, gpio0};

  // Output multiplexers; analog codes release the driver
  logic [4:0] next_out;
  logic [4:0] next_oe;
  logic [4:0] next_ana;
  always_comb begin
    next_out = gpio_out & gpio_sel;
    next_oe  = gpio_oe & gpio_sel;
    next_ana = 5'h0;
    case (pin0_function_field)
      spfs_pkg::CODE_10: begin
        next_out[0] = timer0_output;
        next_oe[0]  = 1'b1;
      end
      spfs_pkg::CODE_11: next_ana[0] = 1'b1;
      default: ;
    endcase
    case (pin1_function_field)
      spfs_pkg::CODE_10: next_ana[1] = 1'b1;
      spfs_pkg::CODE_11: begin
        next_out[1] = timer0_inverted_output;
        next_oe[1]  = 1'b1;
      end
      default: ;
    endcase
    if (pin2_function_field == spfs_pkg::CODE_11) begin
      next_ana[2] = 1'b1;
    end
    case (pin3_function_field)
      spfs_pkg::CODE_01: begin
        next_out[3] = timer1_output;
        next_oe[3]  = 1'b1;
      end
      spfs_pkg::CODE_10: begin
        next_out[3] = serial_a_data_out;
        next_oe[3]  = 1'b1;
      end
      spfs_pkg::CODE_11: next_ana[3] = 1'b1;
      default: ;
    endcase
    if (pin6_function_field == spfs_pkg::CODE_10) begin
      next_out[4] = serial_clock_out;
      next_oe[4]  = serial_clock_oe;
    end
  end

  // Input routing; a gpio-coded pin feeds port and timer clock together, serial data in feeds only the peripheral
  wire [4:0] pin_s = pin_sync[4:0];
  wire next_standard_timer_clock_input = standard_timer_clock_input_from_pin6 ? (gpio6 & pin_s[4]) : (gpio1 & pin_s[1]);
  wire next_serial_a_data_in = serial_a_data_in_from_alt ? pin_sync[5]
                 : (pin6_function_field == spfs_pkg::CODE_01) & pin_s[4];

  // Registered pin and peripheral outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_a_pin_out             <= 5'h0;
      port_a_pin_oe              <= 5'h0;
      pin_analog_en              <= 5'h0;
      gpio_in                    <= 5'h0;
      timer1_capture_input       <= 1'b0;
      timer0_clock_input         <= 1'b0;
      external_interrupt_zero    <= 1'b0;
      standard_timer_clock_input <= 1'b0;
      voltage_detect_en          <= 1'b0;
      timer0_capture_input       <= 1'b0;
      serial_a_data_in           <= 1'b0;
    end else begin
      port_a_pin_out             <= next_out;
      port_a_pin_oe              <= next_oe;
      pin_analog_en              <= next_ana;
      gpio_in                    <= pin_s & gpio_sel;
      timer1_capture_input       <= gpio3 & pin_s[3];
      timer0_clock_input         <= gpio2 & pin_s[2];
      external_interrupt_zero    <= gpio1 & pin_s[1];
      standard_timer_clock_input <= next_standard_timer_clock_input;
      voltage_detect_en          <= pin1_function_field == spfs_pkg::CODE_10;
      timer0_capture_input       <= gpio0 & pin_s[0];
      serial_a_data_in           <= next_serial_a_data_in;
    end
  end

  // Checks
  property p_pin3_timer1;
    @(posedge hclk) disable iff (!hresetn)
      pin3_function_field == spfs_pkg::CODE_01 |=> port_a_pin_oe[3] && port_a_pin_out[3] == $past(timer1_output);
  endproperty
  a_pin3_timer1: assert property (p_pin3_timer1) else $error("pin3 timer1 out wrong");

  property p_pin2_crystal;
    @(posedge hclk) disable iff (!hresetn)
      pin2_function_field == spfs_pkg::CODE_11 |=> pin_analog_en[2] && !port_a_pin_oe[2] && !timer0_clock_input;
  endproperty
  a_pin2_crystal: assert property (p_pin2_crystal) else $error("pin2 crystal code wrong");

  property p_pin1_inv;
    @(posedge hclk) disable iff (!hresetn)
      pin1_function_field == spfs_pkg::CODE_11 |=> port_a_pin_out[1] == $past(timer0_inverted_output);
  endproperty
  a_pin1_inv: assert property (p_pin1_inv) else $error("pin1 inverted timer wrong");

  property p_pin0_timer0;
    @(posedge hclk) disable iff (!hresetn)
      pin0_function_field == spfs_pkg::CODE_10 |=> port_a_pin_oe[0] && port_a_pin_out[0] == $past(timer0_output);
  endproperty
  a_pin0_timer0: assert property (p_pin0_timer0) else $error("pin0 timer0 out wrong");

  property p_write_lands;
    @(posedge hclk) disable iff (!hresetn)
      wr_pend |=> sel_reg[$past(wr_idx)] == ($past(hwdata[7:0]) & spfs_pkg::MASK[$past(wr_idx)]);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("selector write lost");

  property p_standard_timer_clock_input_route;
    @(posedge hclk) disable iff (!hresetn)
      standard_timer_clock_input_from_pin6 && gpio6 ##0 pin_s[4] |=> standard_timer_clock_input;
  endproperty
  a_standard_timer_clock_input_route: assert property (p_standard_timer_clock_input_route) else $error("timer clock route wrong");

  property p_shared_int;
    @(posedge hclk) disable iff (!hresetn)
      gpio1 && pin_s[1] |=> external_interrupt_zero && gpio_in[1];
  endproperty
  a_shared_int: assert property (p_shared_int) else $error("shared input not fed");

  property p_unused_zero;
    @(posedge hclk) disable iff (!hresetn)
      1'b1 |-> (route_a & ~spfs_pkg::MASK[0]) == 8'h00 && (route_b & ~spfs_pkg::MASK[1]) == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unassigned bits not zero");

  property p_pin6_sck;
    @(posedge hclk) disable iff (!hresetn)
      pin6_function_field == spfs_pkg::CODE_10 |=> port_a_pin_oe[4] == $past(serial_clock_oe) && !gpio_in[4];
  endproperty
  a_pin6_sck: assert property (p_pin6_sck) else $error("pin6 serial clock wrong");

  property p_pin3_serial;
    @(posedge hclk) disable iff (!hresetn)
      pin3_function_field == spfs_pkg::CODE_10 |=>
        port_a_pin_oe[3] && port_a_pin_out[3] == $past(serial_a_data_out) && !timer1_capture_input;
  endproperty
  a_pin3_serial: assert property (p_pin3_serial) else $error("pin3 serial out wrong");

  property p_pin2_gpio;
    @(posedge hclk) disable iff (!hresetn)
      pin2_function_field != spfs_pkg::CODE_11 |=>
        !pin_analog_en[2] && timer0_clock_input == $past(pin_s[2]);
  endproperty
  a_pin2_gpio: assert property (p_pin2_gpio) else $error("pin2 timer clock path wrong");

  property p_pin1_lvd;
    @(posedge hclk) disable iff (!hresetn)
      pin1_function_field == spfs_pkg::CODE_10 |=>
        voltage_detect_en && pin_analog_en[1] && !port_a_pin_oe[1] && !external_interrupt_zero;
  endproperty
  a_pin1_lvd: assert property (p_pin1_lvd) else $error("pin1 voltage detect wrong");

  property p_pin0_xtal;
    @(posedge hclk) disable iff (!hresetn)
      pin0_function_field == spfs_pkg::CODE_11 |=>
        pin_analog_en[0] && !port_a_pin_oe[0] && !timer0_capture_input;
  endproperty
  a_pin0_xtal: assert property (p_pin0_xtal) else $error("pin0 crystal code wrong");

  property p_pin6_sdi;
    @(posedge hclk) disable iff (!hresetn)
      pin6_function_field == spfs_pkg::CODE_01 && !serial_a_data_in_from_alt |=>
        serial_a_data_in == $past(pin_s[4]) && !port_a_pin_oe[4];
  endproperty
  a_pin6_sdi: assert property (p_pin6_sdi) else $error("pin6 serial data in wrong");

  // Unmapped words read as zero, so software never sees stale storage
  property p_unmapped_read;
    @(posedge hclk) disable iff (!hresetn)
      addr_ph && !hwrite && !a_mapped |=> hrdata == 32'h0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the pin function selector: register map, port A pin muxing, input routes.
// Assumes one AHB-Lite slave whose hreadyout closes the bus hready loop; all pins driven here.
`timescale 1ns/100ps
module tb_top;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [4:0]  port_a_pin_in, port_a_pin_out, port_a_pin_oe, pin_analog_en, gpio_out, gpio_oe, gpio_in;
  logic        timer1_output, serial_a_data_out, timer0_output, timer0_inverted_output, serial_clock_out;
  logic        serial_clock_oe, serial_a_data_in_alt_pin, timer1_capture_input, timer0_clock_input, external_interrupt_zero;
  logic        standard_timer_clock_input, voltage_detect_en, timer0_capture_input, serial_a_data_in;
  int          err_count, checked;

  spfs_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .port_a_pin_in, .port_a_pin_out, .port_a_pin_oe, .pin_analog_en, .gpio_out, .gpio_oe, .gpio_in,
    .timer1_output, .serial_a_data_out, .timer0_output, .timer0_inverted_output, .serial_clock_out,
    .serial_clock_oe, .serial_a_data_in_alt_pin, .timer1_capture_input, .timer0_clock_input, .external_interrupt_zero,
    .standard_timer_clock_input, .voltage_detect_en, .timer0_capture_input, .serial_a_data_in);

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #10 hclk = ~hclk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One single word transfer; waits on ready, no fixed latency assumed
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {26'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [31:0] unused;
    bus(1'b1, idx, {24'h0, d}, unused);
  endtask

  task automatic rdchk(input logic [3:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    bus(1'b0, idx, 32'h0, rd);
    chk("hrdata", {24'h0, exp}, rd);
  endtask

  // Reset values, then writable masks; 4'he is the first unmapped word
  task automatic test_regs;
    for (int i = 0; i < 15; i++) rdchk(4'(i), spfs_pkg::SEL_RESET);
    for (int i = 0; i < 14; i++) begin
      wr(4'(i), 8'hff);
      rdchk(4'(i), spfs_pkg::MASK[i]);
      wr(4'(i), 8'h00);
      rdchk(4'(i), 8'h00);
    end
    wr(4'he, 8'hff);
    rdchk(4'he, 8'h00);
    chk("hresp", 32'h0, {31'h0, hresp});
    $display("Test regs done");
  endtask

  // Every code on pins 0..3 at once, pins all high; peripheral drives flipped on the second pass
  task automatic test_low;
    logic [1:0] c;
    logic [3:0] g, eo, ee, ea;
    for (int i = 0; i < 8; i++) begin
      c = 2'(i);
      {timer1_output, serial_a_data_out, timer0_output, timer0_inverted_output} <= i[2] ? 4'h5 : 4'ha;
      wr(spfs_pkg::IDX_PORT_A_FUNC_SEL_LOW, {c, c, c, c});
      repeat (4) @(posedge hclk);
      g = {c == 2'h0, c != 2'h3, c[1] == 1'b0, c[1] == 1'b0};
      eo[0] = g[0] ? gpio_out[0] : (c == 2'h2) & timer0_output;
      eo[1] = g[1] ? gpio_out[1] : (c == 2'h3) & timer0_inverted_output;
      eo[2] = g[2] & gpio_out[2];
      eo[3] = g[3] ? gpio_out[3] : (c == 2'h1) ? timer1_output : (c == 2'h2) & serial_a_data_out;
      ee = {g[3] ? gpio_oe[3] : c != 2'h3, g[2] & gpio_oe[2], g[1] ? gpio_oe[1] : c == 2'h3,
            g[0] ? gpio_oe[0] : c == 2'h2};
      ea = {c == 2'h3, c == 2'h3, c == 2'h2, c == 2'h3};
      chk("pin_out", {28'h0, eo}, {28'h0, port_a_pin_out[3:0]});
      chk("pin_oe", {28'h0, ee}, {28'h0, port_a_pin_oe[3:0]});
      chk("analog", {28'h0, ea}, {28'h0, pin_analog_en[3:0]});
      chk("gpio_in", {28'h0, g}, {28'h0, gpio_in[3:0]});
      chk("periph_in", {26'h0, g[3], g[2], g[1], g[1], g[0], c == 2'h2}, {26'h0, timer1_capture_input,
          timer0_clock_input, external_interrupt_zero, standard_timer_clock_input, timer0_capture_input,
          voltage_detect_en});
    end
    wr(spfs_pkg::IDX_PORT_A_FUNC_SEL_LOW, 8'h00);
    $display("Test low done");
  endtask

  // Pin 6 codes under both input routes; pin 6 high, pin 1 low, alternate data pin high
  task automatic test_high;
    logic [1:0] c;
    logic       r, g6;
    port_a_pin_in <= 5'h15;
    serial_a_data_in_alt_pin <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      c = 2'(i);
      r = i[2];
      g6 = (c == 2'h0) || (c == 2'h3);
      wr(spfs_pkg::IDX_INPUT_ROUTE_SELECT_A, {7'h0, r});
      wr(spfs_pkg::IDX_INPUT_ROUTE_SELECT_B, {2'h0, r, 5'h0});
      wr(spfs_pkg::IDX_PORT_A_FUNC_SEL_HIGH, {2'h0, c, 4'h0});
      repeat (4) @(posedge hclk);
      chk("pin6_out", {31'h0, g6 ? gpio_out[4] : (c == 2'h2) & serial_clock_out}, {31'h0, port_a_pin_out[4]});
      chk("pin6_oe", {31'h0, g6 ? gpio_oe[4] : (c == 2'h2) & serial_clock_oe}, {31'h0, port_a_pin_oe[4]});
      chk("pin6_in", {29'h0, g6, r & g6, r | (c == 2'h1)},
          {29'h0, gpio_in[4], standard_timer_clock_input, serial_a_data_in});
    end
    $display("Test high done");
  endtask

  // Live pins: interrupt through the synchroniser, timer0 output started only after its field
  task automatic test_shared;
    gpio_oe <= 5'h00;
    port_a_pin_in <= 5'h00;
    timer0_output <= 1'b0;
    wr(spfs_pkg::IDX_PORT_A_FUNC_SEL_LOW, 8'h02);
    repeat (4) @(posedge hclk);
    chk("ext_int idle", 32'h0, {31'h0, external_interrupt_zero});
    chk("pin1_oe", 32'h0, {31'h0, port_a_pin_oe[1]});
    port_a_pin_in <= 5'h02;
    timer0_output <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("ext_int early", 32'h0, {31'h0, external_interrupt_zero});
    @(posedge hclk);
    chk("ext_int", 32'h1, {31'h0, external_interrupt_zero});
    chk("gpio_in1", 32'h1, {31'h0, gpio_in[1]});
    chk("pin0_out", 32'h1, {31'h0, port_a_pin_out[0]});
    chk("pin0_oe", 32'h1, {31'h0, port_a_pin_oe[0]});
    timer0_output <= 1'b0;
    wr(spfs_pkg::IDX_PORT_A_FUNC_SEL_LOW, 8'h00);
    repeat (2) @(posedge hclk);
    chk("pin0_released", 32'h0, {31'h0, port_a_pin_oe[0]});
    gpio_oe <= 5'h15;
    $display("Test shared done");
  endtask

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Distinct drive values so each source is told apart at the pin
  initial begin
    {hclk, hresetn, hsel, hwrite, haddr, hwdata, htrans, err_count, checked} = '0;
    hsize = 3'b010;
    port_a_pin_in = 5'h1f;
    gpio_out = 5'h0a;
    gpio_oe = 5'h15;
    {timer1_output, serial_a_data_out, timer0_output, timer0_inverted_output} = 4'ha;
    {serial_clock_out, serial_clock_oe, serial_a_data_in_alt_pin} = 3'h6;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    test_regs;
    test_low;
    test_shared;
    test_high;
    wrap_up;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge hclk);
    err_count++;
    wrap_up;
  end
endmodule
